// File: common/alarm_trim_pkg.sv
// constants for the alarm mask, lane fault flags and offset trim register block
// assumes a 32-bit apb master; printed offsets are register indices (byte addr = 4 x index)
package alarm_trim_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    // register indices as printed
    localparam logic [ADDR_W-1:0] IDX_ALARM_SUMMARY = 12'h2c0;
    localparam logic [ADDR_W-1:0] IDX_ALARM_STATUS = 12'h2c1;
    localparam logic [ADDR_W-1:0] IDX_ALARM_GATE_MASK = 12'h2c2;
    localparam logic [ADDR_W-1:0] IDX_LANE_FAULT = 12'h2c4;
    localparam logic [ADDR_W-1:0] IDX_CORE0_TRIM = 12'h330;
    localparam logic [ADDR_W-1:0] IDX_CORE1_TRIM = 12'h332;
    localparam logic [ADDR_W-1:0] IDX_CORE2A_TRIM = 12'h334;
    // register of our own: calibration control and status
    localparam logic [ADDR_W-1:0] IDX_CAL_CTRL = 12'h340;
    localparam int IDX_SHIFT = 2;
    localparam logic [7:0] MASK_RESET = 8'h3f;
    localparam logic [7:0] MASK_WRITABLE = 8'h3d;
    localparam logic [7:0] STATUS_RESET = 8'h3f;
    localparam logic [7:0] STATUS_IMPL = 8'h3d;
    localparam logic [7:0] LANE_RESET = 8'hff;
    localparam int BIT_BUFFER = 5;
    localparam int BIT_SERDES_LOCK = 4;
    localparam int BIT_LINK = 3;
    localparam int BIT_REALIGN = 2;
    localparam int BIT_CLOCK_DIV = 0;
    localparam int TRIM_W = 12;
    localparam int CAL_OFS_BIT = 0;
    localparam int BACKGROUND_CAL_ENABLE_BIT = 1;
    localparam int CAL_TRACK_BIT = 2;
    localparam int CAL_DONE_BIT = 8;
    localparam int CAL_LOCK_BIT = 9;
endpackage

// File: logic/lane_fault_flags.sv
// per-lane sticky buffer fault flags with write-one-to-clear
// assumes lane fault pulses already synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module lane_fault_flags
    import alarm_trim_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [LANES-1:0] laneFault,
    input wire logic [LANES-1:0] clearBits,
    input wire logic clearAll,
    output logic [LANES-1:0] flags
);
    initial begin
        if (LANES < 1 || LANES > 8) $error("lane count out of range");
    end
    logic [LANES-1:0] flags_ff;
    logic [LANES-1:0] nxt_flags;
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            // set wins over a clear in the same cycle
            always_comb begin
                nxt_flags[i] = laneFault[i] | (flags_ff[i] & ~clearBits[i] & ~clearAll); // [R4] [R5] [R6]
            end
        end
    endgenerate
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_ff <= LANE_RESET[LANES-1:0]; // [R7]
        end else begin
            flags_ff <= nxt_flags;
        end
    end
    assign flags = flags_ff;
endmodule
`default_nettype wire

// File: logic/fuse_trim_loader.sv
// loads trim defaults from fuse words one cycle after reset release
// assumes fuse words are stable from reset onward
`timescale 1ns/100ps
`default_nettype none
module fuse_trim_loader
    import alarm_trim_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    output logic loadPulse
);
    logic done_ff;
    logic nxt_done;
    logic pulse_ff;
    logic nxt_pulse;
    always_comb begin
        nxt_done = 1'b1;
        nxt_pulse = ~done_ff; // [R11]
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            done_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            pulse_ff <= nxt_pulse;
        end
    end
    assign loadPulse = pulse_ff;
endmodule
`default_nettype wire

// File: logic/alarm_mask_offset_trim_regs.sv
// apb register block: alarm gate mask, alarm status, lane fault flags, offset trims
// assumes same-clock alarm events; cal engine status is synchronous to core_clk
// Operation
// [R1] a set mask bit keeps its alarm out of the summary bit
// [R2] mask register resets with all five mask bits set
// [R3] software writes reserved bits only with their default value
// [R4] lane i buffer overflow or underflow sets lane fault bit i
// [R5] writing one to a lane fault bit clears it; persistent faults re-set
// [R6] writing one to aggregate buffer status clears all lane bits
// [R7] lane fault register resets to all ones
// [R8] core 0 trim low twelve bits drive core 0 offset correction
// [R9] core 1 trim low twelve bits drive core 1 offset correction
// [R10] core 2 input-a trim used only while core 2 samples input a
// [R11] trim defaults load from fuse storage, not constants
// [R12] software avoids trim access during offset calibration
// [R13] foreground-only offset cal: wait for foreground done before trim access
// [R14] background plus continuous offset tracking: never access trims
// [R15] background without tracking: enable offset and background, not tracking
// [R16] offset cal also trims spare cores in foreground step
// [R17] otherwise trims may be accessed at once
// [R18] summary bit high when any unmasked status bit is set
// [R19] any active lane fault sets aggregate buffer status; write one clears
// [R20] summary tracks mask changes within one clock
`timescale 1ns/100ps
`default_nettype none
module alarm_mask_offset_trim_regs
    import alarm_trim_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LANES-1:0] laneFault,
    input wire logic [LANES-1:0] laneActive,
    input wire logic serdesLockLoss,
    input wire logic linkStateFault,
    input wire logic realignEvent,
    input wire logic clockDividerMismatch,
    input wire logic foregroundCalComplete,
    input wire logic offsetCalBusy,
    input wire logic core2SamplesInputA,
    input wire logic [TRIM_W-1:0] fuseCore0Trim,
    input wire logic [TRIM_W-1:0] fuseCore1Trim,
    input wire logic [TRIM_W-1:0] fuseCore2aTrim,
    output logic summaryAlarm,
    output logic [TRIM_W-1:0] core0OffsetCorr,
    output logic [TRIM_W-1:0] core1OffsetCorr,
    output logic [TRIM_W-1:0] core2OffsetCorr,
    output logic core2OffsetCorrValid,
    output logic offsetCalEnable,
    output logic backgroundCalEnable,
    output logic continuousOffsetTrackEnable,
    output logic spareCoreOffsetCal
);
    initial begin
        if (LANES < 1 || LANES > 8) $error("lane count out of range");
    end

    logic [LANES-1:0] laneFlags;
    logic [LANES-1:0] laneClear;
    logic laneClearAll;
    logic fuseLoad;
    logic [11:0] idx;
    logic wrEn;
    logic rdEn;
    logic lowByteWr;
    logic hiByteWr;
    logic mapped;

    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [15:0] trim0_ff;
    logic [15:0] nxt_trim0;
    logic [15:0] trim1_ff;
    logic [15:0] nxt_trim1;
    logic [15:0] trim2_ff;
    logic [15:0] nxt_trim2;
    logic [2:0] cal_ff;
    logic [2:0] nxt_cal;
    logic summary_ff;
    logic nxt_summary;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic ready_ff;
    logic nxt_ready;
    logic err_ff;
    logic nxt_err;
    logic core2v_ff;
    logic nxt_core2v;
    logic spare_ff;
    logic nxt_spare;
    logic [7:0] statusEvents;
    logic [7:0] laneWide;

    lane_fault_flags #(
        .LANES(LANES)
    ) u_lane_flags (
        .core_clk(core_clk),
        .resetn(resetn),
        .laneFault(laneFault),
        .clearBits(laneClear),
        .clearAll(laneClearAll),
        .flags(laneFlags)
    );

    fuse_trim_loader u_fuse (
        .core_clk(core_clk),
        .resetn(resetn),
        .loadPulse(fuseLoad)
    );

    // one-wait-state slave: setup, then access with pready high for one cycle
    always_comb begin
        idx = paddr[ADDR_W+IDX_SHIFT-1:IDX_SHIFT];
        wrEn = psel & penable & pwrite & ~ready_ff;
        rdEn = psel & penable & ~pwrite & ~ready_ff;
        lowByteWr = wrEn & pstrb[0];
        hiByteWr = wrEn & pstrb[1];
        mapped = (idx == IDX_ALARM_SUMMARY) || (idx == IDX_ALARM_STATUS)
            || (idx == IDX_ALARM_GATE_MASK) || (idx == IDX_LANE_FAULT)
            || (idx == IDX_CORE0_TRIM) || (idx == IDX_CORE1_TRIM)
            || (idx == IDX_CORE2A_TRIM) || (idx == IDX_CAL_CTRL);
        laneWide = '0;
        laneWide[LANES-1:0] = laneFlags;
        laneClear = '0;
        laneClearAll = 1'b0;
        if (lowByteWr && idx == IDX_LANE_FAULT) begin
            laneClear = pwdata[LANES-1:0]; // [R5]
        end
        if (lowByteWr && idx == IDX_ALARM_STATUS && pwdata[BIT_BUFFER]) begin
            laneClearAll = 1'b1; // [R6]
        end
    end

    always_comb begin
        statusEvents = '0;
        statusEvents[BIT_BUFFER] = |(laneFault & laneActive); // [R19]
        statusEvents[BIT_SERDES_LOCK] = serdesLockLoss;
        statusEvents[BIT_LINK] = linkStateFault;
        statusEvents[BIT_REALIGN] = realignEvent;
        statusEvents[BIT_CLOCK_DIV] = clockDividerMismatch;
        nxt_status = status_ff;
        if (lowByteWr && idx == IDX_ALARM_STATUS) begin
            nxt_status = status_ff & ~pwdata[7:0]; // [R19]
        end
        // a new event wins over a same-cycle clear
        nxt_status = (nxt_status | statusEvents) & STATUS_IMPL;
        nxt_mask = mask_ff;
        if (lowByteWr && idx == IDX_ALARM_GATE_MASK) begin
            nxt_mask = (pwdata[7:0] & MASK_WRITABLE) | (MASK_RESET & ~MASK_WRITABLE); // [R3]
        end
        // summary from live status and mask, one flop late
        nxt_summary = |(status_ff & ~mask_ff & STATUS_IMPL); // [R1] [R18] [R20]
    end

    always_comb begin
        nxt_trim0 = trim0_ff;
        nxt_trim1 = trim1_ff;
        nxt_trim2 = trim2_ff;
        nxt_cal = cal_ff;
        if (fuseLoad) begin
            nxt_trim0 = {4'h0, fuseCore0Trim}; // [R11]
            nxt_trim1 = {4'h0, fuseCore1Trim}; // [R11]
            nxt_trim2 = {4'h0, fuseCore2aTrim}; // [R11]
        end else begin
            // no hardware lockout: software keeps clear of the trims while busy
            if (lowByteWr && idx == IDX_CORE0_TRIM) begin
                nxt_trim0[7:0] = pwdata[7:0]; // [R12] [R17]
            end
            if (hiByteWr && idx == IDX_CORE0_TRIM) begin
                nxt_trim0[15:8] = {4'h0, pwdata[11:8]}; // [R3]
            end
            if (lowByteWr && idx == IDX_CORE1_TRIM) begin
                nxt_trim1[7:0] = pwdata[7:0];
            end
            if (hiByteWr && idx == IDX_CORE1_TRIM) begin
                nxt_trim1[15:8] = {4'h0, pwdata[11:8]};
            end
            if (lowByteWr && idx == IDX_CORE2A_TRIM) begin
                nxt_trim2[7:0] = pwdata[7:0];
            end
            if (hiByteWr && idx == IDX_CORE2A_TRIM) begin
                nxt_trim2[15:8] = {4'h0, pwdata[11:8]};
            end
        end
        if (lowByteWr && idx == IDX_CAL_CTRL) begin
            nxt_cal = pwdata[2:0]; // [R13] [R14] [R15]
        end
        nxt_core2v = core2SamplesInputA; // [R10]
        nxt_spare = cal_ff[CAL_OFS_BIT]; // [R16]
    end

    always_comb begin
        nxt_ready = psel & penable & ~ready_ff;
        nxt_err = (wrEn | rdEn) & ~mapped;
        nxt_rdata = '0;
        if (rdEn) begin
            case (idx)
                IDX_ALARM_SUMMARY: nxt_rdata[0] = summary_ff;
                IDX_ALARM_STATUS: nxt_rdata[7:0] = status_ff;
                IDX_ALARM_GATE_MASK: nxt_rdata[7:0] = mask_ff;
                IDX_LANE_FAULT: nxt_rdata[7:0] = laneWide; // [R4]
                IDX_CORE0_TRIM: nxt_rdata[15:0] = trim0_ff;
                IDX_CORE1_TRIM: nxt_rdata[15:0] = trim1_ff;
                IDX_CORE2A_TRIM: nxt_rdata[15:0] = trim2_ff;
                IDX_CAL_CTRL: begin
                    nxt_rdata[2:0] = cal_ff;
                    nxt_rdata[CAL_DONE_BIT] = foregroundCalComplete;
                    nxt_rdata[CAL_LOCK_BIT] = offsetCalBusy;
                end
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= MASK_RESET; // [R2]
            status_ff <= STATUS_RESET & STATUS_IMPL;
            trim0_ff <= '0;
            trim1_ff <= '0;
            trim2_ff <= '0;
            cal_ff <= '0;
            summary_ff <= 1'b0;
            rdata_ff <= '0;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            core2v_ff <= 1'b0;
            spare_ff <= 1'b0;
        end else begin
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
            trim0_ff <= nxt_trim0;
            trim1_ff <= nxt_trim1;
            trim2_ff <= nxt_trim2;
            cal_ff <= nxt_cal;
            summary_ff <= nxt_summary;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff <= nxt_err;
            core2v_ff <= nxt_core2v;
            spare_ff <= nxt_spare;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign summaryAlarm = summary_ff;
    assign core0OffsetCorr = trim0_ff[TRIM_W-1:0]; // [R8]
    assign core1OffsetCorr = trim1_ff[TRIM_W-1:0]; // [R9]
    assign core2OffsetCorr = trim2_ff[TRIM_W-1:0]; // [R10]
    assign core2OffsetCorrValid = core2v_ff;
    assign offsetCalEnable = cal_ff[CAL_OFS_BIT];
    assign backgroundCalEnable = cal_ff[BACKGROUND_CAL_ENABLE_BIT];
    assign continuousOffsetTrackEnable = cal_ff[CAL_TRACK_BIT];
    assign spareCoreOffsetCal = spare_ff;
endmodule
`default_nettype wire

// File: testbench/alarm_trim_sva.sv
// checker: apb answer timing, fuse load, summary hold and echoed control levels
// assumes it is bound to alarm_mask_offset_trim_regs and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module alarm_trim_sva
    import alarm_trim_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core2SamplesInputA,
    input wire logic core2OffsetCorrValid,
    input wire logic offsetCalEnable,
    input wire logic spareCoreOffsetCal,
    input wire logic summaryAlarm,
    input wire logic [TRIM_W-1:0] fuseCore0Trim,
    input wire logic [TRIM_W-1:0] core0OffsetCorr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [1:0] relCnt_ff;
    logic [1:0] nxt_relCnt;
    logic maskSeen_ff;
    logic nxt_maskSeen;
    logic take;
    logic mapped;
    assign take = psel && penable && !pready;
    assign mapped = paddr[13:2] inside {IDX_ALARM_SUMMARY, IDX_ALARM_STATUS, IDX_ALARM_GATE_MASK,
        IDX_LANE_FAULT, IDX_CORE0_TRIM, IDX_CORE1_TRIM, IDX_CORE2A_TRIM, IDX_CAL_CTRL};
    // saturating count of edges since reset release
    always_comb begin
        nxt_relCnt = (relCnt_ff == 2'h3) ? relCnt_ff : relCnt_ff + 2'h1;
        nxt_maskSeen = maskSeen_ff | (take && pwrite && paddr[13:2] == IDX_ALARM_GATE_MASK);
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            relCnt_ff <= 2'h0;
            maskSeen_ff <= 1'b0;
        end else begin
            relCnt_ff <= nxt_relCnt;
            maskSeen_ff <= nxt_maskSeen;
        end
    end
    sequence accStart;
        psel && penable && !pready;
    endsequence
    sequence oneShot;
        pready ##1 !pready;
    endsequence
    a_ready_one_wait: assert property (accStart |=> oneShot)
        else $error("pready not a single pulse after one wait state");
    a_ready_needs_access: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without an access phase");
    a_err_on_unmapped: assert property (accStart |=> pslverr == !$past(mapped))
        else $error("pslverr does not follow the address map");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside the answer cycle");
    a_valid_echoes_sel: assert property ($past(resetn) |->
        core2OffsetCorrValid == $past(core2SamplesInputA)) else $error("core 2 valid lags wrongly");
    a_spare_follows_enable: assert property ($past(resetn) |->
        spareCoreOffsetCal == $past(offsetCalEnable)) else $error("spare core cal not following");
    a_fuse_loads_trim: assert property (relCnt_ff == 2'h2 |->
        core0OffsetCorr == fuseCore0Trim) else $error("core 0 trim not loaded from fuse");
    a_summary_held_masked: assert property (!maskSeen_ff |-> !summaryAlarm)
        else $error("summary raised while every alarm is masked");
endmodule
bind alarm_mask_offset_trim_regs alarm_trim_sva u_sva (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core2SamplesInputA(core2SamplesInputA),
    .core2OffsetCorrValid(core2OffsetCorrValid), .offsetCalEnable(offsetCalEnable),
    .spareCoreOffsetCal(spareCoreOffsetCal), .summaryAlarm(summaryAlarm),
    .fuseCore0Trim(fuseCore0Trim), .core0OffsetCorr(core0OffsetCorr));
`default_nettype wire

// File: testbench/alarm_mask_offset_trim_regs_bench.sv
// testbench: apb scenarios for alarm mask, lane fault flags, trims and cal control
// assumes the checker binds itself; every design input is driven from here
`timescale 1ns/100ps
`default_nettype none
module alarm_mask_offset_trim_regs_bench
    import alarm_trim_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, summaryAlarm, corrValid, calEn, bgEn, trackEn, spare;
    logic [7:0] laneFault = 8'h0, laneActive = 8'hff;
    logic lockLoss = 1'b0, linkFault = 1'b0, realign = 1'b0, divMis = 1'b0;
    logic fgDone = 1'b0, calBusy = 1'b0, sampA = 1'b1;
    logic [TRIM_W-1:0] fuse0 = 12'h5a1, fuse1 = 12'h3c2, fuse2 = 12'h0e7, corr0, corr1, corr2;
    int failures = 0, comparisons = 0, cycles = 0;
    alarm_mask_offset_trim_regs #(.LANES(8)) dut (.core_clk(core_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .laneFault(laneFault), .laneActive(laneActive), .serdesLockLoss(lockLoss),
        .linkStateFault(linkFault), .realignEvent(realign), .clockDividerMismatch(divMis),
        .foregroundCalComplete(fgDone), .offsetCalBusy(calBusy), .core2SamplesInputA(sampA),
        .fuseCore0Trim(fuse0), .fuseCore1Trim(fuse1), .fuseCore2aTrim(fuse2),
        .summaryAlarm(summaryAlarm), .core0OffsetCorr(corr0), .core1OffsetCorr(corr1),
        .core2OffsetCorr(corr2), .core2OffsetCorrValid(corrValid), .offsetCalEnable(calEn),
        .backgroundCalEnable(bgEn), .continuousOffsetTrackEnable(trackEn),
        .spareCoreOffsetCal(spare));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard well above the few hundred cycles the scenarios take
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // setup cycle, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] i, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {18'h0, i, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // no local limit: only the hang guard ends a wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string nm, input logic [ADDR_W-1:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk(nm, e, rd);
    endtask
    task settle;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic pulse(input int b);
        @(posedge core_clk);
        case (b)
            5: laneFault <= 8'h01;
            4: lockLoss <= 1'b1;
            3: linkFault <= 1'b1;
            2: realign <= 1'b1;
            default: divMis <= 1'b1;
        endcase
        @(posedge core_clk);
        {laneFault, lockLoss, linkFault, realign, divMis} <= '0;
    endtask
    task reset_values;
        rchk("mask", IDX_ALARM_GATE_MASK, 32'h3f);
        rchk("lanes", IDX_LANE_FAULT, 32'hff);
        chk("summary", 32'h0, {31'h0, summaryAlarm});
        rchk("summary reg", IDX_ALARM_SUMMARY, 32'h0);
        chk("fuse0", {20'h0, fuse0}, {20'h0, corr0});
        chk("fuse1", {20'h0, fuse1}, {20'h0, corr1});
        chk("fuse2", {20'h0, fuse2}, {20'h0, corr2});
        rchk("trim0", IDX_CORE0_TRIM, {20'h0, fuse0});
        rchk("unmapped", 12'h2c3, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
    endtask
    task lane_faults;
        apb(1'b1, IDX_LANE_FAULT, 32'hff);
        rchk("lane clear", IDX_LANE_FAULT, 32'h0);
        apb(1'b1, IDX_ALARM_STATUS, 32'h3d);
        laneActive <= 8'h7f;
        laneFault <= 8'h80;
        @(posedge core_clk);
        laneFault <= 8'h00;
        rchk("inactive lane", IDX_ALARM_STATUS, 32'h0);
        apb(1'b1, IDX_LANE_FAULT, 32'hff);
        laneActive <= 8'hff;
        laneFault <= 8'h48;
        @(posedge core_clk);
        laneFault <= 8'h40;
        rchk("lane set", IDX_LANE_FAULT, 32'h48);
        rchk("aggregate", IDX_ALARM_STATUS, 32'h20);
        apb(1'b1, IDX_LANE_FAULT, 32'h48);
        rchk("persist", IDX_LANE_FAULT, 32'h40);
        laneFault <= 8'h00;
        apb(1'b1, IDX_ALARM_STATUS, 32'h20);
        rchk("all clear", IDX_LANE_FAULT, 32'h0);
        rchk("agg clear", IDX_ALARM_STATUS, 32'h0);
    endtask
    task automatic summary_gate;
        int bits[5] = '{5, 4, 3, 2, 0};
        foreach (bits[k]) begin
            apb(1'b1, IDX_ALARM_GATE_MASK, 32'h0);
            apb(1'b1, IDX_ALARM_STATUS, 32'h3d);
            settle();
            chk("quiet", 32'h0, {31'h0, summaryAlarm});
            pulse(bits[k]);
            settle();
            chk("raised", 32'h1, {31'h0, summaryAlarm});
            apb(1'b1, IDX_ALARM_GATE_MASK, 32'h3d & ~(32'h1 << bits[k]));
            settle();
            chk("others masked", 32'h1, {31'h0, summaryAlarm});
            apb(1'b1, IDX_ALARM_GATE_MASK, 32'h1 << bits[k]);
            settle();
            chk("own masked", 32'h0, {31'h0, summaryAlarm});
            apb(1'b1, IDX_ALARM_GATE_MASK, 32'h0);
            settle();
            chk("unmasked", 32'h1, {31'h0, summaryAlarm});
            rchk("summary reg", IDX_ALARM_SUMMARY, 32'h1);
        end
    endtask
    task automatic trims;
        logic [ADDR_W-1:0] idx[3] = '{IDX_CORE0_TRIM, IDX_CORE1_TRIM, IDX_CORE2A_TRIM};
        logic [31:0] val[3] = '{32'h0123, 32'h0456, 32'h0789};
        // reserved top bits always written as zero, with calibration idle
        foreach (idx[k]) begin
            apb(1'b1, idx[k], val[k]);
            rchk("trim rw", idx[k], val[k]);
        end
        settle();
        chk("core0 corr", 32'h123, {20'h0, corr0});
        chk("core1 corr", 32'h456, {20'h0, corr1});
        chk("core2 corr", 32'h789, {20'h0, corr2});
        sampA <= 1'b0;
        settle();
        chk("input b", 32'h0, {31'h0, corrValid});
        // low byte strobe only: high byte keeps its old value
        pstrb <= 4'h1;
        apb(1'b1, IDX_CORE0_TRIM, 32'h0abc);
        pstrb <= 4'hf;
        rchk("low byte only", IDX_CORE0_TRIM, 32'h01bc);
        settle();
        chk("core0 strobe", 32'h1bc, {20'h0, corr0});
    endtask
    task cal_ctrl;
        fgDone <= 1'b1;
        apb(1'b1, IDX_CAL_CTRL, 32'h3);
        rchk("cal done", IDX_CAL_CTRL, 32'h103);
        settle();
        chk("cal levels", 32'hd, {28'h0, calEn, bgEn, trackEn, spare});
        calBusy <= 1'b1;
        apb(1'b1, IDX_CAL_CTRL, 32'h7);
        rchk("cal busy", IDX_CAL_CTRL, 32'h307);
        settle();
        chk("cal track", 32'hf, {28'h0, calEn, bgEn, trackEn, spare});
        apb(1'b1, IDX_CAL_CTRL, 32'h0);
        settle();
        chk("cal off", 32'h0, {28'h0, calEn, bgEn, trackEn, spare});
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset_values();
        lane_faults();
        summary_gate();
        trims();
        cal_ctrl();
        end_of_test();
    end
endmodule
`default_nettype wire
